// ===== bench/ssr_cpu_model.sv
// Processor model that answers the supervisor's reset pin and kicks its watchdog line.
`timescale 1ns/1ps
`default_nettype none

module ssr_cpu_model #(
    parameter int unsigned KICK_CYC = 10
) (
    // Clock.
    input wire logic ref_clk,
    // Reset pin from the supervisor, active low, and the bench's kick enable.
    input wire logic cpu_reset_n,
    input wire logic kick_en,
    // Activity line back to the supervisor.
    output logic watchdog_activity_in
);
    int unsigned gap;

    // The line starts low with no kick pending.
    initial
    begin
        gap = 0;
        watchdog_activity_in = 1'b0;
    end

    // A halted processor runs no code, so the line only toggles while out of reset.
    always @(posedge ref_clk)
    begin
        if (!cpu_reset_n || !kick_en)
        begin
            gap <= 0;
        end
        else if (gap == KICK_CYC - 1)
        begin
            gap <= 0;
            watchdog_activity_in <= ~watchdog_activity_in;
        end
        else
        begin
            gap <= gap + 1;
        end
    end
endmodule : ssr_cpu_model

`default_nettype wire

// ===== bench/ssr_supervisor_test.sv
// Self-checking bench for the supply supervisor reset logic.
`timescale 1ns/1ps
`default_nettype none

module ssr_supervisor_test;
    // ************************************************************
    // Stimulus, instances and bookkeeping
    // ************************************************************
    localparam int unsigned TMO = 20;
    localparam int MAN = ssr_pkg::MANUAL_TOTAL_CYC;
    typedef struct packed {
        logic sup;
        logic line;
        logic pf;
        logic exp_line_n;
        logic exp_pf_n;
        logic exp_on;
    } ssr_row_s;
    // Rows: supply low, line low, sense ok, then the expected outputs.
    ssr_row_s rows [7] = '{6'h0E, 6'h1A, 6'h04, 6'h10, 6'h3B, 6'h31, 6'h0F};
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic sup_low = 1'b1;
    logic line_low = 1'b1;
    logic pf_sense = 1'b0;
    logic manual_n = 1'b1;
    logic kick_en = 1'b0;
    logic wd_act;
    logic reset_out;
    logic reset_hi;
    logic low_line_n;
    logic pf_warn_n;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;

    ssr_supervisor #(.RESET_TIMEOUT_CYC(TMO), .WD_TIMEOUT_CYC(50)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .supply_below_reset_in(sup_low),
        .supply_below_lowline_in(line_low), .power_fail_sense_in(pf_sense),
        .manual_reset_request_n(manual_n), .watchdog_activity_in(wd_act),
        .reset_out(reset_out), .low_line_warning_n(low_line_n), .power_fail_warning_n(pf_warn_n));
    // The active-high build sees the same pins and must mirror the first.
    ssr_supervisor #(.RESET_ACTIVE_HIGH(1'b1), .RESET_TIMEOUT_CYC(TMO), .WD_TIMEOUT_CYC(50)) dut_hi (
        .ref_clk(ref_clk), .rst_b(rst_b), .supply_below_reset_in(sup_low),
        .supply_below_lowline_in(line_low), .power_fail_sense_in(pf_sense),
        .manual_reset_request_n(manual_n), .watchdog_activity_in(wd_act),
        .reset_out(reset_hi), .low_line_warning_n(), .power_fail_warning_n());
    ssr_cpu_model cpu (.ref_clk(ref_clk), .cpu_reset_n(reset_out), .kick_en(kick_en),
        .watchdog_activity_in(wd_act));

    // Free-running clock.
    always #5 ref_clk = ~ref_clk;

    // ************************************************************
    // Tasks
    // ************************************************************
    // Compares one bit and reports a mismatch at once.
    task automatic check(input string what, input logic seen, input logic exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
        end
    endtask : check

    // Steps n cycles, checking each one whether reset is held.
    task automatic hold(input int n, input logic exp_on);
        repeat (n)
        begin
            @(negedge ref_clk);
            check("reset level", ~reset_out, exp_on);
        end
    endtask : hold

    // After the last cause clears, reset holds for the timeout and then lets go.
    task automatic release_wait();
        hold(TMO + 1, 1'b1);
        repeat (4) @(negedge ref_clk);
        hold(5, 1'b0);
    endtask : release_wait

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    // The second build always shows the opposite level of the first.
    always @(negedge ref_clk)
    begin
        if (rst_b)
            check("polarity", reset_hi, ~reset_out);
    end

    // Cuts a hang short.
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            err_total++;
            end_of_test();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        int n;
        repeat (12) @(negedge ref_clk);
        check("reset at power-on", reset_out, 1'b0);
        check("line warning at power-on", low_line_n, 1'b0);
        rst_b = 1'b1;
        kick_en = 1'b1;
        sup_low = 1'b0;
        line_low = 1'b0;
        pf_sense = 1'b1;
        repeat (30) @(negedge ref_clk);
        // Table of comparator combinations.
        foreach (rows[i])
        begin
            sup_low = rows[i].sup;
            line_low = rows[i].line;
            pf_sense = rows[i].pf;
            repeat (5) @(negedge ref_clk);
            check("line warning", low_line_n, rows[i].exp_line_n);
            check("power fail warning", pf_warn_n, rows[i].exp_pf_n);
            check("reset level", ~reset_out, rows[i].exp_on);
        end
        repeat (30) @(negedge ref_clk);
        // A dip in mid-timeout restarts the count.
        sup_low = 1'b1;
        repeat (4) @(negedge ref_clk);
        hold(4, 1'b1);
        sup_low = 1'b0;
        hold(12, 1'b1);
        sup_low = 1'b1;
        pf_sense = 1'b0;
        hold(5, 1'b1);
        check("warning during reset", pf_warn_n, 1'b0);
        sup_low = 1'b0;
        pf_sense = 1'b1;
        release_wait();
        // Manual lows that bounce high before qualifying give no reset.
        // Each low stays short of the least qualifying width, so it counts as a bounce.
        manual_n = 1'b0;
        hold(ssr_pkg::MANUAL_MIN_PULSE_CYC - 100, 1'b0);
        manual_n = 1'b1;
        hold(3, 1'b0);
        manual_n = 1'b0;
        hold(ssr_pkg::MANUAL_MIN_PULSE_CYC - 100, 1'b0);
        manual_n = 1'b1;
        hold(10, 1'b0);
        // A qualifying manual low, held well past the least width.
        manual_n = 1'b0;
        hold(MAN - 6, 1'b0);
        repeat (12) @(negedge ref_clk);
        hold(100, 1'b1);
        manual_n = 1'b1;
        release_wait();
        // Watchdog: kicks keep it quiet, silence fires it.
        hold(100, 1'b0);
        kick_en = 1'b0;
        hold(30, 1'b0);
        n = 0;
        while (reset_out === 1'b1 && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("watchdog reset", ~reset_out, 1'b1);
        kick_en = 1'b1;
        repeat (30) @(negedge ref_clk);
        check("after watchdog", reset_out, 1'b1);
        // A second power-on reset in mid-run.
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("reset in reset", reset_out, 1'b0);
        check("warning in reset", pf_warn_n, 1'b0);
        rst_b = 1'b1;
        hold(3, 1'b1);
        repeat (30) @(negedge ref_clk);
        check("after second reset", reset_out, 1'b1);
        end_of_test();
    end
endmodule : ssr_supervisor_test

`default_nettype wire

// ===== hw/ssr_pkg.sv
// Shared constants, types and timing counts for the supply supervisor reset logic.
package ssr_pkg;

    // ************************************************************
    // Timebase
    // ************************************************************
    localparam int unsigned CLK_FREQ_MHZ = 100;

    // ************************************************************
    // Manual reset timing
    // ************************************************************
    localparam int unsigned MANUAL_MIN_PULSE_WIDTH_NS = 25000;
    localparam int unsigned MANUAL_TO_RESET_DELAY_NS = 12000;
    // A least width rounds up to whole cycles.
    localparam int unsigned MANUAL_MIN_PULSE_CYC = (MANUAL_MIN_PULSE_WIDTH_NS * CLK_FREQ_MHZ + 999) / 1000;
    // The delay is a typical figure, so it rounds to the nearest cycle.
    localparam int unsigned MANUAL_TO_RESET_DELAY_CYC = (MANUAL_TO_RESET_DELAY_NS * CLK_FREQ_MHZ + 500) / 1000;
    localparam int unsigned MANUAL_TOTAL_CYC = MANUAL_MIN_PULSE_CYC + MANUAL_TO_RESET_DELAY_CYC;
    localparam int unsigned MANUAL_CNT_W = $clog2(MANUAL_TOTAL_CYC + 1);

    // ************************************************************
    // Reset and watchdog timeouts
    // ************************************************************
    localparam int unsigned RESET_TIMEOUT_US = 200;
    localparam int unsigned RESET_TIMEOUT_CYC = RESET_TIMEOUT_US * CLK_FREQ_MHZ;
    localparam int unsigned WD_TIMEOUT_US = 6200;
    localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_US * CLK_FREQ_MHZ;

    // ************************************************************
    // Types
    // ************************************************************
    // Synchronised comparator results and pins, in one word.
    typedef struct packed {
        logic supply_low;
        logic line_low;
        logic pf_ok;
        logic manual_n;
        logic wd_act;
    } ssr_pins_s;

    // Power-up assumes low supply, idle manual input and failing sense.
    localparam ssr_pins_s PINS_RESET_VAL = '{supply_low: 1'b1, line_low: 1'b1, pf_ok: 1'b0,
                                            manual_n: 1'b1, wd_act: 1'b0};

    // Reset sequencer states.
    typedef enum logic [1:0] {
        ST_HOLD,
        ST_TIMEOUT,
        ST_RUN
    } ssr_state_e;

endpackage : ssr_pkg

// ===== hw/ssr_supervisor.sv
// Supervisory reset, watchdog and warning logic for a microprocessor.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE1 - Reset is asserted whenever the supply is below the reset threshold.
// RULE2 - Reset is released only after the supply stays good for the whole timeout, restarting on a dip.
// RULE3 - The reset output polarity is a build option while the internal condition stays the same.
// RULE4 - The manual input is debounced so short low bounces cause no reset, and idles inactive.
// RULE5 - A manual low held past 25 us asserts reset after a further 12 us.
// RULE6 - Reset stays on while the manual input is low and ends one timeout after it rises.
// RULE7 - Outside logic may pull the manual input low and should hold it past the qualifying width.
// RULE8 - The power-fail warning is low while the sense input is below reference and high otherwise.
// RULE9 - The power-fail path and the reset path never affect each other.
// RULE10 - The low-line warning goes low when the supply is below the low-line threshold.
// RULE11 - Every edge on the watchdog activity input clears the watchdog counter.
// RULE12 - A watchdog counter reaching its timeout without activity asserts reset.
// RULE13 - Reset and watchdog timeouts are build parameters in timebase counts.
// RULE14 - All comparator and pin inputs are synchronised before use.

module ssr_supervisor #(
    parameter bit RESET_ACTIVE_HIGH = 1'b0,
    parameter int unsigned RESET_TIMEOUT_CYC = ssr_pkg::RESET_TIMEOUT_CYC,
    parameter int unsigned WD_TIMEOUT_CYC = ssr_pkg::WD_TIMEOUT_CYC
) (
    // Clock and power-on reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Comparator results.
    input wire logic supply_below_reset_in,
    input wire logic supply_below_lowline_in,
    input wire logic power_fail_sense_in,
    // Processor side pins.
    input wire logic manual_reset_request_n,
    input wire logic watchdog_activity_in,
    // Outputs.
    output logic reset_out,
    output logic low_line_warning_n,
    output logic power_fail_warning_n
);

    // ************************************************************
    // Widths and build checks
    // ************************************************************
    localparam int unsigned RW = $clog2(RESET_TIMEOUT_CYC + 1);
    localparam int unsigned WW = $clog2(WD_TIMEOUT_CYC + 1);
    localparam int unsigned MW = ssr_pkg::MANUAL_CNT_W;
    localparam logic ASSERT_LVL = RESET_ACTIVE_HIGH;

    // Counters below assume at least two cycles of timeout.
    if (RESET_TIMEOUT_CYC < 2 || WD_TIMEOUT_CYC < 2)
    begin : g_bad_param
        $error("Timeout counts must be at least two cycles.");
    end

    // ************************************************************
    // Input synchronisation
    // ************************************************************
    ssr_pkg::ssr_pins_s pins_raw;
    ssr_pkg::ssr_pins_s pins;

    // Gather the asynchronous levels into one word.
    assign pins_raw = '{supply_low: supply_below_reset_in, line_low: supply_below_lowline_in,
                        pf_ok: power_fail_sense_in, manual_n: manual_reset_request_n,
                        wd_act: watchdog_activity_in};

    ssr_sync #(
        .WIDTH($bits(ssr_pkg::ssr_pins_s)),
        .RESET_VAL(ssr_pkg::PINS_RESET_VAL)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in(pins_raw),
        .sync_out(pins)
    ); // see RULE14

    // ************************************************************
    // Manual reset qualification
    // ************************************************************
    logic [MW-1:0] man_cnt;
    logic [MW-1:0] next_man_cnt;
    logic manual_hold;
    logic next_manual_hold;

    // Count low time; any high level restarts it, which filters bounces.
    always_comb
    begin
        if (pins.manual_n)
        begin
            next_man_cnt = '0; // see RULE4
        end
        else if (man_cnt != MW'(ssr_pkg::MANUAL_TOTAL_CYC))
        begin
            next_man_cnt = man_cnt + 1'b1; // see RULE5
        end
        else
        begin
            next_man_cnt = man_cnt;
        end
        next_manual_hold = (next_man_cnt == MW'(ssr_pkg::MANUAL_TOTAL_CYC)); // see RULE6
    end

    // Register the qualifier.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            man_cnt <= '0;
            manual_hold <= 1'b0;
        end
        else
        begin
            man_cnt <= next_man_cnt;
            manual_hold <= next_manual_hold;
        end
    end

    // ************************************************************
    // Watchdog
    // ************************************************************
    ssr_pkg::ssr_state_e state;
    ssr_pkg::ssr_state_e next_state;
    logic wd_prev;
    logic wd_edge;
    logic [WW-1:0] wd_cnt;
    logic [WW-1:0] next_wd_cnt;
    logic wd_fire;
    logic next_wd_fire;

    // Edges clear the count; it also rests while reset is active.
    always_comb
    begin
        wd_edge = pins.wd_act ^ wd_prev;
        next_wd_fire = (state == ssr_pkg::ST_RUN) && !wd_edge
                       && (wd_cnt == WW'(WD_TIMEOUT_CYC - 1)); // see RULE12
        if (wd_edge || wd_fire || state != ssr_pkg::ST_RUN)
        begin
            next_wd_cnt = '0; // see RULE11
        end
        else
        begin
            next_wd_cnt = wd_cnt + 1'b1;
        end
    end

    // Register the watchdog state.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wd_prev <= 1'b0;
            wd_cnt <= '0;
            wd_fire <= 1'b0;
        end
        else
        begin
            wd_prev <= pins.wd_act;
            wd_cnt <= next_wd_cnt;
            wd_fire <= next_wd_fire;
        end
    end

    // ************************************************************
    // Reset sequencer
    // ************************************************************
    logic cause;
    logic [RW-1:0] rst_cnt;
    logic [RW-1:0] next_rst_cnt;
    logic next_reset_out;

    // Hold while any cause is present, then time out before release.
    always_comb
    begin
        cause = pins.supply_low | manual_hold | wd_fire; // see RULE1
        next_state = state;
        next_rst_cnt = rst_cnt;
        unique case (state)
            ssr_pkg::ST_HOLD:
            begin
                next_rst_cnt = '0;
                if (!cause)
                begin
                    next_state = ssr_pkg::ST_TIMEOUT;
                end
            end
            ssr_pkg::ST_TIMEOUT:
            begin
                if (cause)
                begin
                    next_state = ssr_pkg::ST_HOLD; // see RULE2
                    next_rst_cnt = '0;
                end
                else if (rst_cnt == RW'(RESET_TIMEOUT_CYC - 1))
                begin
                    next_state = ssr_pkg::ST_RUN; // see RULE13
                    next_rst_cnt = '0;
                end
                else
                begin
                    next_rst_cnt = rst_cnt + 1'b1;
                end
            end
            ssr_pkg::ST_RUN:
            begin
                if (cause)
                begin
                    next_state = ssr_pkg::ST_HOLD;
                end
            end
        endcase
        next_reset_out = (next_state != ssr_pkg::ST_RUN) ? ASSERT_LVL : ~ASSERT_LVL; // see RULE3
    end

    // Register the sequencer and its output.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= ssr_pkg::ST_HOLD;
            rst_cnt <= '0;
            reset_out <= ASSERT_LVL;
        end
        else
        begin
            state <= next_state;
            rst_cnt <= next_rst_cnt;
            reset_out <= next_reset_out;
        end
    end

    // ************************************************************
    // Warning outputs
    // ************************************************************
    logic next_pf_warn_n;
    logic next_ll_warn_n;

    // Both warnings follow their comparators and nothing else.
    always_comb
    begin
        next_pf_warn_n = pins.pf_ok; // see RULE8
        next_ll_warn_n = ~pins.line_low; // see RULE10
    end

    // Register the warnings.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            power_fail_warning_n <= 1'b0;
            low_line_warning_n <= 1'b0;
        end
        else
        begin
            power_fail_warning_n <= next_pf_warn_n; // see RULE9
            low_line_warning_n <= next_ll_warn_n;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    logic rst_on;
    logic [1:0] warm;

    // Output level seen as asserted, and a settle count for path latency.
    assign rst_on = (reset_out == ASSERT_LVL);
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            warm <= 2'h0;
        end
        else if (warm != 2'h3)
        begin
            warm <= warm + 2'h1;
        end
    end

    chk_supply_low_reset: assert property (pins.supply_low |=> rst_on [*2]) // see RULE1
        else $error("Reset not held during low supply.");
    chk_timeout_release: assert property ($fell(rst_on) |-> $past(state) == ssr_pkg::ST_TIMEOUT
        && $past(rst_cnt) == RW'(RESET_TIMEOUT_CYC - 1)) // see RULE2
        else $error("Reset released before the full timeout.");
    chk_dip_restart: assert property (state == ssr_pkg::ST_TIMEOUT && cause |=>
        state == ssr_pkg::ST_HOLD && rst_on ##1 rst_cnt == '0) // see RULE2
        else $error("Timeout did not restart on a new cause.");
    chk_reset_polarity: assert property (reset_out == ((state != ssr_pkg::ST_RUN) ~^ ASSERT_LVL)) // see RULE3
        else $error("Reset output level does not match its state.");
    chk_bounce_ignored: assert property (pins.manual_n |=> man_cnt == '0 && !manual_hold) // see RULE4
        else $error("Manual qualifier not restarted by a high level.");
    chk_manual_delay: assert property ($rose(manual_hold) |-> $past(man_cnt)
        == MW'(ssr_pkg::MANUAL_TOTAL_CYC - 1) && $past(!pins.manual_n)) // see RULE5
        else $error("Manual reset asserted at the wrong time.");
    chk_manual_hold: assert property (manual_hold && !pins.manual_n |=> manual_hold ##1 rst_on) // see RULE6
        else $error("Reset not held while manual input low.");
    chk_pf_follow: assert property (warm == 2'h3 |-> power_fail_warning_n
        == $past(power_fail_sense_in, 3)) // see RULE8
        else $error("Power-fail warning does not follow its sense input.");
    chk_pf_isolated: assert property ($stable(pins.pf_ok) |=> $stable(power_fail_warning_n)) // see RULE9
        else $error("Power-fail warning moved without its input.");
    chk_low_line: assert property (warm == 2'h3 |-> low_line_warning_n
        == !$past(supply_below_lowline_in, 3)) // see RULE10
        else $error("Low-line warning does not follow its comparator.");
    chk_wd_clear: assert property (wd_edge |=> wd_cnt == '0) // see RULE11
        else $error("Watchdog count not cleared by activity.");
    chk_wd_fire: assert property (state == ssr_pkg::ST_RUN && !wd_edge
        && wd_cnt == WW'(WD_TIMEOUT_CYC - 1) |=> wd_fire ##1 rst_on) // see RULE12
        else $error("Watchdog expiry did not assert reset.");

    cov_manual_reset: cover property ($rose(manual_hold));
    cov_wd_fire: cover property (wd_fire ##1 rst_on);
    cov_release: cover property ($fell(rst_on));
    cov_dip: cover property (state == ssr_pkg::ST_TIMEOUT && pins.supply_low);

endmodule : ssr_supervisor

`default_nettype wire

// ===== hw/ssr_sync.sv
// Two-flop synchroniser for a vector of independent asynchronous levels.
`timescale 1ns/1ps
`default_nettype none

module ssr_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Levels in and out.
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ************************************************************
    // Per-bit stages
    // ************************************************************
    logic [WIDTH-1:0] meta;

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        // The first stage feeds only the second stage.
        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                meta[i] <= RESET_VAL[i];
                sync_out[i] <= RESET_VAL[i];
            end
            else
            begin
                meta[i] <= async_in[i];
                sync_out[i] <= meta[i];
            end
        end
    end

endmodule : ssr_sync

`default_nettype wire
